// file: iwoc_defs.vh
// constants for the option-word configured independent watchdog
`ifndef IWOC_DEFS_VH
`define IWOC_DEFS_VH

// register bus shape
`define IWOC_AW             12
`define IWOC_DW             32

// register byte addresses
`define IWOC_REFRESH_ADDR   12'h000
`define IWOC_STATUS_ADDR    12'h004
`define IWOC_IRQ_STS_ADDR   12'h008
`define IWOC_IRQ_MASK_ADDR  12'h00C
`define IWOC_CAUSE_CLR_ADDR 12'h010
`define IWOC_OPTION_ADDR    12'h400

// option word field positions
`define IWOC_OPT_START_BIT  1
`define IWOC_OPT_TOP_LSB    2
`define IWOC_OPT_TOP_MSB    3
`define IWOC_OPT_CKS_LSB    4
`define IWOC_OPT_CKS_MSB    7
`define IWOC_OPT_WEND_LSB   8
`define IWOC_OPT_WEND_MSB   9
`define IWOC_OPT_WSTA_LSB   10
`define IWOC_OPT_WSTA_MSB   11
`define IWOC_OPT_ACT_BIT    12
`define IWOC_OPT_STP_BIT    14

// time-out periods in divided watchdog clock cycles
`define IWOC_CNT_W          12
`define IWOC_TOP_128        12'h080
`define IWOC_TOP_512        12'h200
`define IWOC_TOP_1024       12'h400
`define IWOC_TOP_2048       12'h800

// prescale codes and their terminal counts (divisor minus one)
`define IWOC_CKS_DIV1       4'h0
`define IWOC_CKS_DIV16      4'h2
`define IWOC_CKS_DIV32      4'h3
`define IWOC_CKS_DIV64      4'h4
`define IWOC_CKS_DIV128     4'hF
`define IWOC_CKS_DIV256     4'h5
`define IWOC_PRE_W          8
`define IWOC_TC_DIV1        8'h00
`define IWOC_TC_DIV16       8'h0F
`define IWOC_TC_DIV32       8'h1F
`define IWOC_TC_DIV64       8'h3F
`define IWOC_TC_DIV128      8'h7F
`define IWOC_TC_DIV256      8'hFF

// interrupt status bits
`define IWOC_IRQ_W          2
`define IWOC_IRQ_UNDER      0
`define IWOC_IRQ_REFERR     1

// reset values
`define IWOC_OPT_RST        32'h00000000
`define IWOC_MASK_RST       2'h0

// cycles the option word settles through the synchroniser before capture
`define IWOC_OPT_SETTLE     2'h3

`endif

// file: iwoc_prescaler.v
// divides the sampled watchdog source clock by the selected ratio
`include "iwoc_defs.vh"
module iwoc_prescaler (
	input  wire       clk,
	input  wire       sys_rst,
	input  wire       srcTick,
	input  wire       countEn,
	input  wire       restart,
	input  wire [3:0] divSel,
	output reg        divTick
);

	reg [`IWOC_PRE_W-1:0] preCnt_q;
	reg [`IWOC_PRE_W-1:0] termCnt;

	// unlisted codes fall back to divide by one
	always @* begin
		case (divSel)
			`IWOC_CKS_DIV16:  termCnt = `IWOC_TC_DIV16;
			`IWOC_CKS_DIV32:  termCnt = `IWOC_TC_DIV32;
			`IWOC_CKS_DIV64:  termCnt = `IWOC_TC_DIV64;
			`IWOC_CKS_DIV128: termCnt = `IWOC_TC_DIV128;
			`IWOC_CKS_DIV256: termCnt = `IWOC_TC_DIV256;
			default:          termCnt = `IWOC_TC_DIV1;
		endcase
	end

	// restart drops any partial division so a fresh period is whole
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			preCnt_q <= {`IWOC_PRE_W{1'b0}};
			divTick  <= 1'b0;
		end else begin
			divTick <= 1'b0;
			if (restart) begin
				preCnt_q <= {`IWOC_PRE_W{1'b0}};
			end else if (countEn && srcTick) begin
				if (preCnt_q >= termCnt) begin
					preCnt_q <= {`IWOC_PRE_W{1'b0}};
					divTick  <= 1'b1;
				end else begin
					preCnt_q <= preCnt_q + 8'h01;
				end
			end
		end
	end

endmodule // iwoc_prescaler

// file: iwoc_sync.v
// two-flop synchroniser for pins from outside the clock domain
module iwoc_sync #(
	parameter WIDTH = 1
) (
	input  wire             clk,
	input  wire             sys_rst,
	input  wire [WIDTH-1:0] asyncIn,
	output reg  [WIDTH-1:0] syncOut
);

	reg [WIDTH-1:0] meta_q;

	// first stage feeds only the second stage
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_q  <= {WIDTH{1'b0}};
			syncOut <= {WIDTH{1'b0}};
		end else begin
			meta_q  <= asyncIn;
			syncOut <= meta_q;
		end
	end

endmodule // iwoc_sync

// file: iwoc_watchdog.v
// independent watchdog configured at reset by a non-volatile option word
// register map, byte addresses
//   0x000 refresh, write any data
//   0x004 status: [11:0] count, [12] running, [13] watchdog caused the last reset
//   0x008 event status, a read clears it: [0] underflow, [1] refresh error
//   0x00C event mask, same layout as the event status
//   0x010 cause clear, write bit 0 high
//   0x400 captured option word, read only
//
// timing
//   option word taken on the fourth edge after reset release, auto-start one edge later
//   refresh writes before that capture are dropped, so early software waits a few cycles
//   error action is a one-cycle pulse two edges after the offending tick or write
//   the event bit lands with the action pulse, the interrupt level one edge later
//
// limitations
//   the source clock pin is sampled, so it must stay high and low for a system clock each
//   after an error the counter stays stopped until software refreshes it again
//   reserved option bits are not checked; a wrong word still configures the block
//   the cause flag clears only on power-on reset or an explicit clear write
//   a pending divided tick is dropped when sleep freezes the count
//
// The address-and-strobe port is this design's own decision.
`include "iwoc_defs.vh"
module iwoc_watchdog (
	input  wire                 clk,
	input  wire                 sys_rst,
	input  wire                 pwrOnRst,
	input  wire                 srcClkPin,
	input  wire [`IWOC_DW-1:0]  optWordPin,
	input  wire                 sleepIn,
	input  wire [`IWOC_AW-1:0]  regAddr,
	input  wire [`IWOC_DW-1:0]  regWrData,
	input  wire                 regWr,
	input  wire                 regRd,
	output reg  [`IWOC_DW-1:0]  regRdData,
	output reg                  irqOut,
	output reg                  nmiOut,
	output reg                  resetReq
);

	// synchronised pins
	wire [`IWOC_DW-1:0]   optSync;
	wire                  srcSync;
	reg                   srcPrev_q;
	wire                  srcTick;

	// option word capture
	reg  [1:0]            optWait_q;
	reg                   optLoaded_q;
	reg  [`IWOC_DW-1:0]   opt_q;

	// decoded option fields
	wire                  startDis;
	wire [1:0]            topSel;
	wire [3:0]            cksSel;
	wire [1:0]            wEndSel;
	wire [1:0]            wStaSel;
	wire                  actReset;
	wire                  sleepStop;

	// counter and window
	reg  [`IWOC_CNT_W-1:0] period;
	reg  [`IWOC_CNT_W-1:0] openLimit;
	reg  [`IWOC_CNT_W-1:0] closeLimit;
	wire [`IWOC_CNT_W-1:0] quarter;
	wire [`IWOC_CNT_W-1:0] half;
	wire [`IWOC_CNT_W-1:0] threeQ;
	reg  [`IWOC_CNT_W-1:0] cnt_q;
	reg                    running_q;
	reg                    autoDone_q;
	wire                   autoGo;
	wire                   inWindow;
	wire                   countEn;
	wire                   divTick;
	reg                    reload;

	// register access decode
	wire                   wrRefresh;
	wire                   wrMask;
	wire                   wrCauseClr;
	wire                   rdIrqSts;

	// events and flags
	reg                    evUnder_q;
	reg                    evRefErr_q;
	wire                   errEv;
	reg  [`IWOC_IRQ_W-1:0] irqSts_q;
	reg  [`IWOC_IRQ_W-1:0] irqMask_q;
	reg                    cause_q;
	reg  [`IWOC_DW-1:0]    rdMux;

	// watchdog source clock is sampled, not used as a clock
	iwoc_sync #(
		.WIDTH(1)
	) u_srcSync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.asyncIn (srcClkPin),
		.syncOut (srcSync)
	);

	// the option word comes from storage outside this clock domain
	iwoc_sync #(
		.WIDTH(`IWOC_DW)
	) u_optSync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.asyncIn (optWordPin),
		.syncOut (optSync)
	);

	// rising edge of the sampled source clock, read from the second stage only
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			srcPrev_q <= 1'b0;
		end else begin
			srcPrev_q <= srcSync;
		end
	end

	assign srcTick = srcSync & ~srcPrev_q;

	// capture the option word once the synchroniser has settled after release
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			optWait_q   <= 2'h0;
			optLoaded_q <= 1'b0;
			opt_q       <= `IWOC_OPT_RST;
		end else if (!optLoaded_q) begin
			if (optWait_q == `IWOC_OPT_SETTLE) begin
				opt_q       <= optSync;
				optLoaded_q <= 1'b1;
			end else begin
				optWait_q <= optWait_q + 2'h1;
			end
		end
	end

	// fields are frozen until the next system reset
	assign startDis  = opt_q[`IWOC_OPT_START_BIT];
	assign topSel    = opt_q[`IWOC_OPT_TOP_MSB:`IWOC_OPT_TOP_LSB];
	assign cksSel    = opt_q[`IWOC_OPT_CKS_MSB:`IWOC_OPT_CKS_LSB];
	assign wEndSel   = opt_q[`IWOC_OPT_WEND_MSB:`IWOC_OPT_WEND_LSB];
	assign wStaSel   = opt_q[`IWOC_OPT_WSTA_MSB:`IWOC_OPT_WSTA_LSB];
	assign actReset  = opt_q[`IWOC_OPT_ACT_BIT];
	assign sleepStop = opt_q[`IWOC_OPT_STP_BIT];

	// time-out period selection
	always @* begin
		case (topSel)
			2'h0:    period = `IWOC_TOP_128;
			2'h1:    period = `IWOC_TOP_512;
			2'h2:    period = `IWOC_TOP_1024;
			default: period = `IWOC_TOP_2048;
		endcase
	end

	// periods are powers of two, so the fractions are exact
	assign quarter = period >> 2;
	assign half    = period >> 1;
	assign threeQ  = half + quarter;

	// window opens once the count has fallen to this value
	always @* begin
		case (wStaSel)
			2'h0:    openLimit = quarter;
			2'h1:    openLimit = half;
			2'h2:    openLimit = threeQ;
			default: openLimit = period;
		endcase
	end

	// window closes once the count falls below this value
	always @* begin
		case (wEndSel)
			2'h0:    closeLimit = threeQ;
			2'h1:    closeLimit = half;
			2'h2:    closeLimit = quarter;
			default: closeLimit = {`IWOC_CNT_W{1'b0}};
		endcase
	end

	// percentages are measured against the remaining count
	assign inWindow = (cnt_q <= openLimit) && (cnt_q >= closeLimit);

	// sleep only freezes the count when the option word asks for it
	assign countEn = running_q && !(sleepStop && sleepIn);

	// auto-start fires once, as soon as the option word is in place
	assign autoGo = optLoaded_q && !startDis && !autoDone_q;

	// register strobes
	assign wrRefresh  = regWr && (regAddr == `IWOC_REFRESH_ADDR);
	assign wrMask     = regWr && (regAddr == `IWOC_IRQ_MASK_ADDR);
	assign wrCauseClr = regWr && (regAddr == `IWOC_CAUSE_CLR_ADDR) && regWrData[0];
	assign rdIrqSts   = regRd && (regAddr == `IWOC_IRQ_STS_ADDR);

	// a start or a valid refresh reloads the period
	always @* begin
		reload = 1'b0;
		if (autoGo) begin
			reload = 1'b1;
		end else if (wrRefresh && optLoaded_q) begin
			reload = !running_q || inWindow;
		end
	end

	// prescaler also restarts on reload so each period is exact
	iwoc_prescaler u_pre (
		.clk     (clk),
		.sys_rst (sys_rst),
		.srcTick (srcTick),
		.countEn (countEn),
		.restart (reload),
		.divSel  (cksSel),
		.divTick (divTick)
	);

	// down-counter; an error stops it until software refreshes again
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q      <= {`IWOC_CNT_W{1'b0}};
			running_q  <= 1'b0;
			autoDone_q <= 1'b0;
			evUnder_q  <= 1'b0;
			evRefErr_q <= 1'b0;
		end else begin
			evUnder_q  <= 1'b0;
			evRefErr_q <= 1'b0;
			if (optLoaded_q) begin
				autoDone_q <= 1'b1;
			end
			if (reload) begin
				cnt_q     <= period;
				running_q <= 1'b1;
			end else if (wrRefresh && running_q) begin
				evRefErr_q <= 1'b1;
				running_q  <= 1'b0;
			end else if (countEn && divTick) begin
				cnt_q <= cnt_q - 12'h001;
				if (cnt_q == 12'h001) begin
					evUnder_q <= 1'b1;
					running_q <= 1'b0;
				end
			end
		end
	end

	// either event drives the single error action
	assign errEv = evUnder_q | evRefErr_q;

	// error action; outputs are one-cycle pulses from flops
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			nmiOut   <= 1'b0;
			resetReq <= 1'b0;
		end else begin
			nmiOut   <= errEv && !actReset;
			resetReq <= errEv && actReset;
		end
	end

	// the cause flag survives the system reset it requested; only power-on or a cause clear write clears it
	always @(posedge clk or posedge pwrOnRst) begin
		if (pwrOnRst) begin
			cause_q <= 1'b0;
		end else if (errEv && actReset) begin
			cause_q <= 1'b1;
		end else if (wrCauseClr) begin
			cause_q <= 1'b0;
		end
	end

	// sticky event bits; a new event beats the read that clears them
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irqSts_q <= {`IWOC_IRQ_W{1'b0}};
		end else begin
			irqSts_q <= (rdIrqSts ? {`IWOC_IRQ_W{1'b0}} : irqSts_q)
				| {evRefErr_q, evUnder_q};
		end
	end

	// mask register
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irqMask_q <= `IWOC_MASK_RST;
		end else if (wrMask) begin
			irqMask_q <= regWrData[`IWOC_IRQ_W-1:0];
		end
	end

	// level interrupt, one cycle behind the status bits
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irqOut <= 1'b0;
		end else begin
			irqOut <= |(irqSts_q & irqMask_q);
		end
	end

	// read decode; unmapped addresses read zero
	always @* begin
		rdMux = {`IWOC_DW{1'b0}};
		if (regAddr == `IWOC_STATUS_ADDR) begin
			rdMux = {18'h00000, cause_q, running_q, cnt_q};
		end else if (regAddr == `IWOC_IRQ_STS_ADDR) begin
			rdMux = {30'h00000000, irqSts_q};
		end else if (regAddr == `IWOC_IRQ_MASK_ADDR) begin
			rdMux = {30'h00000000, irqMask_q};
		end else if (regAddr == `IWOC_OPTION_ADDR) begin
			rdMux = opt_q;
		end
	end

	// read data stands only in the cycle after the strobe
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			regRdData <= {`IWOC_DW{1'b0}};
		end else if (regRd) begin
			regRdData <= rdMux;
		end else begin
			regRdData <= {`IWOC_DW{1'b0}};
		end
	end

endmodule // iwoc_watchdog

// file: iwoc_watchdog_checker.sv
// port-level assertions for the option-word watchdog
`include "iwoc_defs.vh"
module iwoc_watchdog_checker (
	input logic        clk,
	input logic        sys_rst,
	input logic [31:0] optWordPin,
	input logic        sleepIn,
	input logic [11:0] regAddr,
	input logic        regWr,
	input logic        regRd,
	input logic [31:0] regRdData,
	input logic        irqOut,
	input logic        nmiOut,
	input logic        resetReq
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic [2:0] upCnt_q;
	wire        maskWr = regWr && (regAddr == `IWOC_IRQ_MASK_ADDR);
	wire        act = nmiOut || resetReq;
	// edges since reset release; the option copy is settled once this saturates
	always @(posedge clk or posedge sys_rst)
		if (sys_rst)
			upCnt_q <= 3'h0;
		else if (upCnt_q != 3'h7)
			upCnt_q <= upCnt_q + 3'h1;
	AST_NMI_SEL: assert property (nmiOut |-> !optWordPin[`IWOC_OPT_ACT_BIT])
		else $error("interrupt action with reset selected");
	AST_RST_SEL: assert property (resetReq |-> optWordPin[`IWOC_OPT_ACT_BIT])
		else $error("reset action with interrupt selected");
	AST_ACT_EXCL: assert property (!(nmiOut && resetReq))
		else $error("both error actions at once");
	AST_ACT_GAP: assert property (act |=> !act [*8])
		else $error("error action repeated too soon");
	AST_NO_EARLY: assert property (upCnt_q < 3'h4 |-> !act)
		else $error("action before option capture");
	AST_RD_IDLE: assert property (!$past(regRd) |-> regRdData == 32'h0)
		else $error("read data outside its cycle");
	AST_RD_OPT: assert property (regRd && regAddr == `IWOC_OPTION_ADDR && upCnt_q == 3'h7
		|=> regRdData == $past(optWordPin)) else $error("option word readback wrong");
	AST_SLEEP: assert property ((optWordPin[`IWOC_OPT_STP_BIT] && sleepIn) [*4] |-> !act)
		else $error("action while frozen in sleep");
	AST_IRQ_CAUSE: assert property ($rose(irqOut) |-> $past(act) || $past(maskWr) || $past(maskWr, 2))
		else $error("interrupt rose without cause");
	cover property (nmiOut);
	cover property (resetReq);
	cover property ($rose(irqOut));
endmodule // iwoc_watchdog_checker

// file: iwoc_watchdog_tb.sv
// self-checking bench for the option-word watchdog
`include "iwoc_defs.vh"
module iwoc_watchdog_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, sys_rst, pwrOnRst, srcClkPin, sleepIn, regWr, regRd;
	logic        irqOut, nmiOut, resetReq;
	logic [31:0] optWordPin, regWrData, regRdData, d;
	logic [11:0] regAddr;
	int          fails, checks, cyc, n, c1, c2, p;
	int          cksT[7] = '{0, 2, 3, 4, 15, 5, 1};
	int          divT[7] = '{1, 16, 32, 64, 128, 256, 1};
	int          wsT[7] = '{0, 0, 3, 3, 2, 1, 1};
	int          weT[7] = '{3, 3, 0, 0, 2, 2, 1};
	int          tgT[7] = '{40, 28, 90, 100, 60, 70, 50};
	localparam logic [31:0] BASE = 32'h0000A001; // reserved ones in bits 0, 13, 15
	iwoc_watchdog dut (.clk, .sys_rst, .pwrOnRst, .srcClkPin, .optWordPin, .sleepIn, .regAddr,
		.regWrData, .regWr, .regRd, .regRdData, .irqOut, .nmiOut, .resetReq);
	// reference figures from the period and window tables
	function automatic int per(int t);
		return t == 0 ? 128 : 256 << t;
	endfunction
	function automatic bit winOk(int c, int ws, int we);
		return c <= (ws < 3 ? 32 * (ws + 1) : 128) && c >= (we < 3 ? 32 * (3 - we) : 0);
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= v;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1 d = regRdData;
	endtask
	// new option word only takes effect through a system reset
	task automatic cfg(input logic [31:0] o);
		@(posedge clk);
		sys_rst <= 1'b1;
		optWordPin <= o;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (6) @(posedge clk);
	endtask
	task automatic waitAct(input int lim);
		n = 0;
		while (n < lim && nmiOut !== 1'b1 && resetReq !== 1'b1) begin
			@(posedge clk);
			#1 n++;
		end
	endtask
	task close_out;
		if (fails == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// source clock at half the system rate, so one divided tick per two cycles at div 1
	always @(posedge clk) begin
		srcClkPin <= ~srcClkPin;
		cyc++;
		if (cyc == 60000) begin
			fails++;
			close_out();
		end
	end
	initial begin
		{sys_rst, pwrOnRst, srcClkPin, sleepIn, regWr, regRd} = 6'h30;
		{regWrData, regAddr} = 44'h0;
		optWordPin = BASE;
		void'($urandom(33170));
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		pwrOnRst <= 1'b0;
		repeat (6) @(posedge clk);
		rd(`IWOC_IRQ_MASK_ADDR); chk(d, 32'h0);
		rd(`IWOC_OPTION_ADDR); chk(d, BASE);
		rd(12'h020); chk(d, 32'h0);
		wr(`IWOC_OPTION_ADDR, $urandom);
		rd(`IWOC_OPTION_ADDR); chk(d, BASE);
		rd(`IWOC_STATUS_ADDR); chk(d[13], 1'b0);
		// underflow with interrupt action and unmasked status
		wr(`IWOC_IRQ_MASK_ADDR, 32'h3);
		rd(`IWOC_IRQ_MASK_ADDR); chk(d, 32'h3);
		rd(`IWOC_STATUS_ADDR); c1 = d[11:0];
		waitAct(1000);
		chk(nmiOut, 1'b1);
		chk(n >= 2 * c1 - 4 && n <= 2 * c1 + 6, 1'b1);
		@(posedge clk);
		#1 chk(irqOut, 1'b1);
		rd(`IWOC_IRQ_STS_ADDR); chk(d[1:0], 2'h1);
		repeat (2) @(posedge clk);
		#1 chk(irqOut, 1'b0);
		rd(`IWOC_STATUS_ADDR); chk(d[12], 1'b0);
		// reset action, then the cause flag survives a system reset
		cfg(BASE | 32'h00001000);
		waitAct(1000);
		chk(resetReq, 1'b1);
		@(posedge clk);
		#1 chk(irqOut, 1'b0);
		cfg(BASE | 32'h00001000);
		rd(`IWOC_STATUS_ADDR); chk(d[13], 1'b1);
		wr(`IWOC_CAUSE_CLR_ADDR, 32'h1);
		rd(`IWOC_STATUS_ADDR); chk(d[13], 1'b0);
		// a second watchdog reset, then a power-on reset clears the cause flag
		waitAct(1000);
		chk(resetReq, 1'b1);
		@(posedge clk) pwrOnRst <= 1'b1;
		@(posedge clk) pwrOnRst <= 1'b0;
		rd(`IWOC_STATUS_ADDR); chk(d[13], 1'b0);
		// every period code with auto-start
		for (int t = 0; t < 4; t++) begin
			cfg(BASE | (t << 2));
			rd(`IWOC_STATUS_ADDR); p = per(t);
			chk(d[12] && d[11:0] <= p && d[11:0] > p - 8, 1'b1);
		end
		// every listed prescale code and unlisted code 1: four divided ticks over eight times the divisor
		for (int i = 0; i < 7; i++) begin
			cfg(BASE | 32'hC | (cksT[i] << 4));
			rd(`IWOC_STATUS_ADDR); c1 = d[11:0];
			repeat (8 * divT[i] - 2) @(posedge clk);
			rd(`IWOC_STATUS_ADDR); c2 = d[11:0];
			chk(c1 - c2, 32'h4);
		end
		// sleep with counting continued and stopped
		for (int s = 0; s < 2; s++) begin
			cfg(BASE | 32'hC | (s << 14));
			@(posedge clk) sleepIn <= 1'b1;
			rd(`IWOC_STATUS_ADDR); c1 = d[11:0];
			repeat (18) @(posedge clk);
			rd(`IWOC_STATUS_ADDR); c2 = d[11:0];
			chk(c1 - c2, s ? 0 : 10);
			sleepIn <= 1'b0;
		end
		// refresh inside or outside the window, over every start and end code
		for (int k = 0; k < 7; k++) begin
			cfg(BASE | 32'h2 | (wsT[k] << 10) | (weT[k] << 8));
			rd(`IWOC_STATUS_ADDR); chk(d[12], 1'b0);
			wr(`IWOC_REFRESH_ADDR, $urandom);
			n = 0;
			do begin
				rd(`IWOC_STATUS_ADDR);
				n++;
			end while (d[11:0] > tgT[k] && n < 300);
			c1 = d[11:0];
			wr(`IWOC_REFRESH_ADDR, $urandom);
			waitAct(6);
			chk(nmiOut, !winOk(c1 - 1, wsT[k], weT[k]));
			rd(`IWOC_IRQ_STS_ADDR); chk(d[1], !winOk(c1 - 1, wsT[k], weT[k]));
			rd(`IWOC_STATUS_ADDR); chk(d[11:0] > 100, winOk(c1 - 1, wsT[k], weT[k]));
		end
		close_out();
	end
endmodule // iwoc_watchdog_tb
bind iwoc_watchdog iwoc_watchdog_checker chk_i (.clk, .sys_rst, .optWordPin, .sleepIn, .regAddr,
	.regWr, .regRd, .regRdData, .irqOut, .nmiOut, .resetReq);
